/* File: hdl/sram_slot_map.vh */
// register offsets, field positions and constants of the sram slot controller
`ifndef SRAM_SLOT_MAP_VH
`define SRAM_SLOT_MAP_VH
// ***********************************************************
// register byte offsets
// ***********************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_WRPTR 8'h08
`define REG_RDPTR 8'h0C
`define REG_HOSTDATA 8'h10
`define REG_PIXDATA 8'h14
`define REG_DRIVE 8'h18
// ***********************************************************
// control fields
// ***********************************************************
`define CTRL_SIZE_LSB 0
`define CTRL_ACC_LSB 2
`define CTRL_DPI600_BIT 4
`define CTRL_SCAN_BIT 5
`define CTRL_RESET 32'h0000_0000
`define DRIVE_LSB 2
// ***********************************************************
// encodings and counts
// ***********************************************************
`define SIZE_64K 2'h0
`define SIZE_128K 2'h1
`define SIZE_256K 2'h2
`define ACC_8B4S 2'h0
`define ACC_8B8S 2'h1
`define ACC_12B4S 2'h2
`define ACC_12B8S 2'h3
`define COEF_300 18'h04000
`define COEF_600 18'h08000
`define PIX_MAX_300 13'h0AA9
`define PIX_MAX_600 13'h1554
`define SLOTS_PER_PIXEL 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hdl/scanner_sram_slot_controller.v */
// external sram slot controller with axi4-lite register access
//
// Overview of operation
// - 300 dpi: 16 KB coefficient region, up to 2729 pixels.
// - 600 dpi: 32 KB coefficient region, up to 5460 pixels.
// - remaining memory is a circular image buffer, pixel writes, host reads.
// - memory size selectable: 64K, 128K or 256K bytes.
// - 64K: address lines 0-15, line 16 is inverse of line 15.
// - 128K: address lines 0-16, line 17 is inverse of line 16.
// - 256K: all eighteen address lines as plain binary.
// - four access modes: 8b/4 slot, 8b/8 slot, 12b/4 slot, 12b/8 slot.
// - pixel period is eight master clocks; coefficients fetched every period.
// - 8b/4 slot: coefficient reads, pixel write, host read take two clocks.
// - 8b/8 slot: every read access takes one clock.
// - 8b/8 slot: four host-read slots per pixel period.
// - 12-bit samples stored as high byte (4 msbs) then low byte.
// - 12b/4 slot: host slot writes second byte; no host reads while scanning.
// - 12b/8 slot: coefficient and host byte reads one clock each.
// - 12b/8 slot: high and low byte writes get two clocks each.
// - 12b/8 slot: host reads run concurrently with scanning.
// - drive strength of memory outputs follows a two-bit setting.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sram_slot_map.vh"
module scanner_sram_slot_controller #(
	parameter AW = 18,
	parameter SLOTS = `SLOTS_PER_PIXEL
) (
	input wire clk_sys,
	input wire rst_b,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire pixValid,
	input wire [11:0] pixData,
	output reg pixReady,
	output reg [7:0] coefOffset,
	output reg [7:0] coefGain,
	output reg coefValid,
	output reg [AW-1:0] memAddr,
	output reg [7:0] memDataOut,
	input wire [7:0] memDataIn,
	output reg memDataOe_b,
	output reg memRd_b,
	output reg memWr_b,
	output wire [1:0] memDrive,
	output reg pixelStrobe
);
	// ***********************************************************
	// slot kinds
	// ***********************************************************
	localparam K_IDLE = 3'h0;
	localparam K_COFS = 3'h1;
	localparam K_CGAIN = 3'h2;
	localparam K_WLO = 3'h3;
	localparam K_WHI = 3'h4;
	localparam K_HOST = 3'h5;

	// slot kind for mode and phase of the pixel period
	function [2:0] slotKind;
		input [1:0] acc;
		input [2:0] ph;
		begin
			case (acc)
				`ACC_8B4S: begin
					case (ph[2:1])
						2'h0: slotKind = K_COFS;
						2'h1: slotKind = K_CGAIN;
						2'h2: slotKind = K_WLO;
						default: slotKind = K_HOST;
					endcase
				end
				`ACC_8B8S: begin
					case (ph)
						3'h0: slotKind = K_COFS;
						3'h1: slotKind = K_CGAIN;
						3'h2, 3'h3: slotKind = K_WLO;
						default: slotKind = K_HOST;
					endcase
				end
				// host slot carries the second byte write
				`ACC_12B4S: begin
					case (ph[2:1])
						2'h0: slotKind = K_COFS;
						2'h1: slotKind = K_CGAIN;
						2'h2: slotKind = K_WHI;
						default: slotKind = K_WLO;
					endcase
				end
				default: begin
					case (ph)
						3'h0: slotKind = K_COFS;
						3'h1: slotKind = K_CGAIN;
						3'h2, 3'h3: slotKind = K_WHI;
						3'h4, 3'h5: slotKind = K_WLO;
						default: slotKind = K_HOST;
					endcase
				end
			endcase
		end
	endfunction

	// ***********************************************************
	// registers
	// ***********************************************************
	reg [31:0] ctrl_r;
	reg [1:0] drive_r;
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] level_r;
	reg [12:0] pixIdx_r;
	reg [2:0] phase_r;
	reg [7:0] hostData_r;
	reg hostValid_r;
	reg hostReq_r;
	reg [11:0] pixHold_r;
	reg scanRun_r;
	reg capOfs_r;
	reg capGain_r;
	reg capHost_r;
	reg pixHave_r;
	reg awHave_r;
	reg wHave_r;
	reg [7:0] awAddr_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;

	wire [1:0] sizeSel = ctrl_r[`CTRL_SIZE_LSB+1:`CTRL_SIZE_LSB];
	wire [1:0] accMode = ctrl_r[`CTRL_ACC_LSB+1:`CTRL_ACC_LSB];
	wire dpi600 = ctrl_r[`CTRL_DPI600_BIT];
	wire scanOn = ctrl_r[`CTRL_SCAN_BIT];
	assign memDrive = drive_r;

	// ***********************************************************
	// memory layout
	// ***********************************************************
	// coefficient region size
	wire [AW-1:0] coefBytes = dpi600 ? `COEF_600 : `COEF_300;
	wire [12:0] pixMax = dpi600 ? `PIX_MAX_600 : `PIX_MAX_300;
	reg [AW:0] memBytes;
	always @* begin
		case (sizeSel)
			`SIZE_64K: memBytes = 19'h10000;
			`SIZE_128K: memBytes = 19'h20000;
			default: memBytes = 19'h40000;
		endcase
	end
	wire [AW:0] bufBytes = memBytes - {1'b0, coefBytes};
	wire [AW-1:0] bufTop = memBytes[AW-1:0] - 18'h00001;
	wire bufFull = (level_r >= bufBytes - 19'h00001);
	wire bufEmpty = (level_r == 19'h00000);

	function [AW-1:0] ptrInc;
		input [AW-1:0] p;
		input [AW-1:0] top;
		input [AW-1:0] base;
		begin
			ptrInc = (p == top) ? base : p + 18'h00001;
		end
	endfunction

	// ***********************************************************
	// slot sequencer
	// ***********************************************************
	wire [2:0] kindRaw = slotKind(accMode, phase_r);
	// second-byte slot serves the host once scanning stops
	wire [2:0] kind = (accMode == `ACC_12B4S && !scanRun_r &&
		phase_r[2:1] == 2'h3) ? K_HOST : kindRaw;
	// two-clock slots act on their second clock
	wire twoClk = (accMode == `ACC_8B4S) || (accMode == `ACC_12B4S) ||
		(kind == K_WHI) || (kind == K_WLO);
	wire slotEnd = !twoClk || phase_r[0];
	wire is12 = accMode[1];
	// no host reads in half duplex while scanning
	wire hostAllowed = !(accMode == `ACC_12B4S && scanRun_r);
	// full duplex permits host reads during scanning
	wire hostGo = (kind == K_HOST) && hostAllowed && hostReq_r &&
		!hostValid_r && !capHost_r && !bufEmpty;
	wire wrGo = scanRun_r && pixHave_r && !bufFull;
	wire doWrite = wrGo && (kind == K_WLO || (kind == K_WHI && is12));
	wire doRead = (kind == K_COFS) || (kind == K_CGAIN) || hostGo;
	wire wrDone = slotEnd && wrGo && (kind == K_WLO);
	wire hiDone = slotEnd && wrGo && (kind == K_WHI) && is12;
	wire hostDone = slotEnd && hostGo;

	// logical address for this slot
	reg [AW-1:0] logAddr;
	always @* begin
		case (kind)
			K_COFS: logAddr = {{(AW-15){1'b0}}, pixIdx_r, 2'h0};
			K_CGAIN: logAddr = {{(AW-15){1'b0}}, pixIdx_r, 2'h1};
			K_WLO, K_WHI: logAddr = wrPtr_r;
			default: logAddr = rdPtr_r;
		endcase
	end
	reg [AW-1:0] physAddr;
	always @* begin
		physAddr = logAddr;
		case (sizeSel)
			`SIZE_64K: physAddr = {1'b0, ~logAddr[15], logAddr[15:0]};
			`SIZE_128K: physAddr = {~logAddr[16], logAddr[16:0]};
			default: physAddr = logAddr;
		endcase
	end
	wire [7:0] wrByte = (kind == K_WHI) ? {4'h0, pixHold_r[11:8]} :
		(is12 ? pixHold_r[7:0] : pixHold_r[11:4]);

	// pixel period counter and memory pins
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= 3'h0;
			pixIdx_r <= 13'h0000;
			memAddr <= 18'h00000;
			memDataOut <= 8'h00;
			memDataOe_b <= 1'b1;
			memRd_b <= 1'b1;
			memWr_b <= 1'b1;
			coefOffset <= 8'h00;
			coefGain <= 8'h00;
			coefValid <= 1'b0;
			pixelStrobe <= 1'b0;
			scanRun_r <= 1'b0;
			capOfs_r <= 1'b0;
			capGain_r <= 1'b0;
		end else begin
			phase_r <= phase_r + 3'h1;
			pixelStrobe <= (phase_r == 3'h7);
			memAddr <= physAddr;
			memDataOut <= wrByte;
			memDataOe_b <= !doWrite;
			memRd_b <= !doRead;
			memWr_b <= !doWrite;
			// read data shows on the pins one clock after the slot
			capOfs_r <= slotEnd && kind == K_COFS;
			capGain_r <= slotEnd && kind == K_CGAIN;
			coefValid <= capGain_r;
			if (capOfs_r)
				coefOffset <= memDataIn;
			if (capGain_r)
				coefGain <= memDataIn;
			if (phase_r == 3'h7) begin
				scanRun_r <= scanOn;
				pixIdx_r <= (!scanOn || pixIdx_r == pixMax) ? 13'h0000 :
					pixIdx_r + 13'h0001;
			end
		end
	end

	wire arFire = s_axi_arvalid && s_axi_arready;
	wire hostRead = arFire && (s_axi_araddr == `REG_HOSTDATA) && hostValid_r;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_r <= `COEF_300;
			rdPtr_r <= `COEF_300;
			level_r <= 19'h00000;
			pixHold_r <= 12'h000;
			pixHave_r <= 1'b0;
			pixReady <= 1'b0;
			hostData_r <= 8'h00;
			hostValid_r <= 1'b0;
			capHost_r <= 1'b0;
		end else begin
			pixReady <= !pixHave_r && !pixReady;
			if (pixValid && pixReady) begin
				pixHold_r <= pixData;
				pixHave_r <= 1'b1;
				pixReady <= 1'b0;
			end
			if (!scanOn) begin
				wrPtr_r <= (level_r == 19'h00000) ? coefBytes : wrPtr_r;
			end
			if (wrDone || hiDone)
				wrPtr_r <= ptrInc(wrPtr_r, bufTop, coefBytes);
			if (wrDone)
				pixHave_r <= 1'b0;
			capHost_r <= hostDone;
			if (hostDone)
				rdPtr_r <= ptrInc(rdPtr_r, bufTop, coefBytes);
			if (level_r == 19'h00000 && !scanOn && !hostDone)
				rdPtr_r <= coefBytes;
			level_r <= level_r + {18'h0, (wrDone || hiDone)} -
				{18'h0, hostDone};
			if (hostRead)
				hostValid_r <= 1'b0;
			if (capHost_r) begin
				hostData_r <= memDataIn;
				hostValid_r <= 1'b1;
			end
		end
	end

	// ***********************************************************
	// axi4-lite slave
	// ***********************************************************
	assign s_axi_awready = !awHave_r && !s_axi_bvalid;
	assign s_axi_wready = !wHave_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire doWr = awHave_r && wHave_r;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			ctrl_r <= `CTRL_RESET;
			drive_r <= 2'h0;
			hostReq_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWr) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (awAddr_r)
					`REG_CTRL: if (wStrb_r[0])
						ctrl_r <= {26'h0, wData_r[5:0]};
					`REG_DRIVE: if (wStrb_r[0])
						drive_r <= wData_r[`DRIVE_LSB+1:`DRIVE_LSB];
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// host requests a byte whenever the buffer is not empty and none is held
			if (hostValid_r)
				hostReq_r <= 1'b0;
			else if (!bufEmpty)
				hostReq_r <= 1'b1;
			if (arFire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr)
					`REG_CTRL: s_axi_rdata <= ctrl_r;
					`REG_STATUS: s_axi_rdata <= {26'h0, hostValid_r,
						pixHave_r, bufEmpty, bufFull, 2'h0};
					`REG_WRPTR: s_axi_rdata <= {14'h0, wrPtr_r};
					`REG_RDPTR: s_axi_rdata <= {14'h0, rdPtr_r};
					`REG_HOSTDATA: s_axi_rdata <= {23'h0, hostValid_r,
						hostData_r};
					`REG_PIXDATA: s_axi_rdata <= {13'h0, level_r};
					`REG_DRIVE: s_axi_rdata <= {28'h0, drive_r, 2'h0};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // scanner_sram_slot_controller

/* File: verification/sram_slot_monitor.sv */
// port assertions of the sram slot controller
`timescale 1ns/1ps
module sram_slot_monitor (
	input wire clk_sys,
	input wire rst_b,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire memRd_b,
	input wire memWr_b,
	input wire memDataOe_b,
	input wire pixelStrobe,
	input wire coefValid
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// ***
	// pixel period
	// ***
	sequence quietSeven;
		!pixelStrobe [*7];
	endsequence
	sequence nextPixel;
		quietSeven ##1 pixelStrobe;
	endsequence
	chk_pixel_period: assert property (pixelStrobe |=> nextPixel)
		else $error("pixel period not eight clocks");
	chk_coef_once: assert property (coefValid |=> !coefValid [*7])
		else $error("two coefficient pairs in one period");
	chk_one_slot: assert property (!(!memRd_b && !memWr_b))
		else $error("read and write strobes together");
	chk_wr_drives: assert property (!memWr_b |-> !memDataOe_b)
		else $error("write without data drive");
	chk_rd_floats: assert property (!memRd_b |-> memDataOe_b)
		else $error("read while driving data");
	chk_wr_twice: assert property ($fell(memWr_b) |=> !memWr_b)
		else $error("write strobe shorter than two clocks");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while rvalid");
	chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while bvalid");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // sram_slot_monitor
bind scanner_sram_slot_controller sram_slot_monitor u_sram_slot_monitor (.*);

/* File: verification/sram_chip_model.sv */
// byte-wide asynchronous sram behind the slot controller
`timescale 1ns/1ps
module sram_chip_model (
	input wire clk_sys,
	input wire [17:0] memAddr,
	input wire [7:0] memDataOut,
	input wire memDataOe_b,
	input wire memRd_b,
	input wire memWr_b,
	output logic [7:0] memDataIn
);
	logic [7:0] cells [0:262143];
	logic [7:0] lastRd;
	initial begin
		lastRd = 8'h00;
		for (int i = 0; i < 262144; i++) cells[i] = i[7:0] ^ 8'hA5;
	end
	always @(posedge clk_sys) begin
		if (!memWr_b && !memDataOe_b) cells[memAddr] <= memDataOut;
		if (!memRd_b) lastRd <= cells[memAddr];
	end
	// released bus shows no stale byte
	assign memDataIn = memRd_b ? ~lastRd : cells[memAddr];
endmodule // sram_chip_model

/* File: verification/tb.sv */
// self-checking bench of the sram slot controller
`timescale 1ns/1ps
`include "sram_slot_map.vh"
module tb;
	logic clk_sys, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, pixValid, pixReady;
	logic coefValid, memDataOe_b, memRd_b, memWr_b, pixelStrobe;
	logic [7:0] s_axi_awaddr, s_axi_araddr, coefOffset, coefGain;
	logic [7:0] memDataOut, memDataIn;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, memDrive, rs;
	logic [11:0] pixData;
	logic [17:0] memAddr;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	scanner_sram_slot_controller u_scanner_sram_slot_controller (.*);
	sram_chip_model u_sram_chip_model (.*);
	initial begin
		// 100 ns period, within the 8b8s limit
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	// ***
	// helpers
	// ***
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic bit byteOk(logic [1:0] m, logic [11:0] v, logic [7:0] b);
		if (m[1]) return b === {4'h0, v[11:8]} || b === v[7:0];
		return b === v[11:4];
	endfunction
	function automatic bit mapOk(input logic [1:0] sz, input logic [17:0] a);
		if (sz == `SIZE_64K) return a[16] === ~a[15];
		if (sz == `SIZE_128K) return a[17] === ~a[16];
		return a[17:16] === 2'h0;
	endfunction
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic axiRead(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic runMode(input logic [1:0] m, input logic [1:0] sz);
		int wr, cv, bad, amap, bc;
		logic [11:0] v;
		logic [7:0] oc;
		seed = xorshift(seed);
		v = seed[11:0];
		wr = 0;
		cv = 0;
		bad = 0;
		amap = 0;
		bc = 0;
		pixData <= v;
		pixValid <= 1'h1;
		axiWrite(`REG_CTRL, {26'h0, 1'h1, sz != `SIZE_64K, m, sz});
		repeat (24) @(posedge clk_sys);
		// drops a byte fetched before the scan took effect
		axiRead(`REG_HOSTDATA);
		repeat (64) begin
			@(negedge clk_sys);
			if (coefValid) begin
				cv++;
				oc = coefOffset ^ 8'hA5;
				bc += (oc[1:0] != 2'h0) ||
					((coefGain ^ 8'hA5) != oc + 8'h01);
			end
			if (!memWr_b) begin
				wr++;
				bad += !byteOk(m, v, memDataOut);
				amap += !mapOk(sz, memAddr);
			end
		end
		@(posedge clk_sys);
		check("coef pairs", 32'h8, 32'(cv));
		check("coef bytes", 32'h0, 32'(bc));
		check("write clocks", m[1] ? 32'h20 : 32'h10, 32'(wr));
		check("write bytes", 32'h0, 32'(bad));
		check("address map", 32'h0, 32'(amap));
		axiRead(`REG_HOSTDATA);
		if (m == `ACC_12B4S) check("host in scan", 32'h0, 32'(rd[8]));
		if (m == `ACC_12B8S) check("host in scan", 32'h1, 32'(rd[8]));
		pixValid <= 1'h0;
		axiWrite(`REG_CTRL, {28'h0, m, sz});
		repeat (32) @(posedge clk_sys);
		axiRead(`REG_HOSTDATA);
		if (m == `ACC_12B4S) check("host after stop", 32'h1, 32'(rd[8]));
		$display("mode %0d size %0d done", m, sz);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ***
	// main sequence
	// ***
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, pixValid} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, pixData} = 28'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		seed = 32'hC2C9;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'h1;
		@(posedge clk_sys);
		axiRead(`REG_CTRL);
		check("ctrl reset", `CTRL_RESET, rd);
		axiRead(8'h1C);
		check("unmapped read", 32'(`RESP_SLVERR), 32'(rs));
		axiWrite(8'h1C, 32'h0);
		check("unmapped write", 32'(`RESP_SLVERR), 32'(rs));
		for (int i = 0; i < 4; i++) begin
			axiWrite(`REG_DRIVE, 32'(i) << `DRIVE_LSB);
			check("drive", 32'(i), 32'(memDrive));
		end
		$display("register test done");
		for (int a = 0; a < 4; a++)
			for (int s = 0; s < 3; s++)
				runMode(a[1:0], s[1:0]);
		final_report();
	end
endmodule // tb
